//--- rtl/timer_unit.sv
// Three timer/counter channels behind special function registers.
// Assumes a single-cycle register port driven by the processor core.
`timescale 1ns/1ps
`default_nettype none
module timer_unit (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  // External pins
  input wire logic COUNT0_PIN,
  input wire logic COUNT1_PIN,
  input wire logic COUNT2_PIN,
  input wire logic TIMER2_TRIGGER_PIN,
  input wire logic EXT_INT0_PIN,
  input wire logic EXT_INT1_PIN,
  // Interrupt requests and vector acknowledges
  output logic TIMER0_IRQ,
  output logic TIMER1_IRQ,
  output logic TIMER2_IRQ,
  input wire logic VECTOR0_ACK,
  input wire logic VECTOR1_ACK,
  // Serial port clock pulses
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK
);

  typedef struct packed {
    logic [7:0] timer_mode_register;
    logic [7:0] timer_control;
    logic [7:0] timer0_low_byte;
    logic [7:0] timer0_high_byte;
    logic [7:0] timer1_low_byte;
    logic [7:0] timer1_high_byte;
    logic [7:0] timer2_control;
    logic [7:0] capture_reload_low;
    logic [7:0] capture_reload_high;
    logic [7:0] timer2_low_byte;
    logic [7:0] timer2_high_byte;
    logic [7:0] rdata;
    logic rx_tick;
    logic tx_tick;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ----------------------------------------------------------------
  // Machine cycle and pin sampling
  // ----------------------------------------------------------------
  logic mtick;
  logic ph_ten;
  logic ph_nine;
  logic [timer_unit_pkg::NUM_PINS-1:0] pins;
  logic [timer_unit_pkg::NUM_PINS-1:0] lvl;
  logic [timer_unit_pkg::NUM_PINS-1:0] fall;

  mcycle_gen u_mcycle (
    .clk(MCLK),
    .rst(RST),
    .mtick(mtick),
    .ph_ten(ph_ten),
    .ph_nine(ph_nine)
  );

  assign pins = {EXT_INT1_PIN, EXT_INT0_PIN, TIMER2_TRIGGER_PIN,
                 COUNT2_PIN, COUNT1_PIN, COUNT0_PIN};

  genvar g;
  generate
    for (g = 0; g < timer_unit_pkg::NUM_PINS; g++) begin : g_pin
      // timer 2 pins on phase nine
      localparam bit T2_SIDE = (g == timer_unit_pkg::PIN_COUNT2) ||
                               (g == timer_unit_pkg::PIN_TRIGGER);
      event_sampler u_samp (
        .clk(MCLK),
        .rst(RST),
        .pin(pins[g]),
        .strobe(T2_SIDE ? ph_nine : ph_ten),
        .level(lvl[g]),
        .fall(fall[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decoded control fields
  // ----------------------------------------------------------------
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic en0;
  logic en1;
  logic tick0;
  logic tick1;
  logic tick0h;
  logic baud;
  logic tick2;
  logic t2_ovf;
  logic trig;
  logic cap_sel;
  logic [15:0] t2_cnt;

  assign mode0 = st_q.timer_mode_register[timer_unit_pkg::MODE0_LSB +: 2];
  assign mode1 = st_q.timer_mode_register[timer_unit_pkg::MODE1_LSB +: 2];
  // split low byte keeps timer 0 controls
  assign en0 = st_q.timer_control[timer_unit_pkg::T0_RUN_BIT] &
    (~st_q.timer_mode_register[timer_unit_pkg::GATE0_BIT] |
     lvl[timer_unit_pkg::PIN_INT0]);
  assign en1 = st_q.timer_control[timer_unit_pkg::T1_RUN_BIT] &
    (~st_q.timer_mode_register[timer_unit_pkg::GATE1_BIT] |
     lvl[timer_unit_pkg::PIN_INT1]) & (mode1 != timer_unit_pkg::MODE_SPLIT);
  assign tick0 = en0 & (st_q.timer_mode_register[timer_unit_pkg::CT0_BIT] ?
    fall[timer_unit_pkg::PIN_COUNT0] : mtick);
  assign tick1 = en1 & (st_q.timer_mode_register[timer_unit_pkg::CT1_BIT] ?
    fall[timer_unit_pkg::PIN_COUNT1] : mtick);
  // split high byte on timer 1 run bit
  assign tick0h = (mode0 == timer_unit_pkg::MODE_SPLIT) & mtick &
    st_q.timer_control[timer_unit_pkg::T1_RUN_BIT];

  assign baud = st_q.timer2_control[timer_unit_pkg::RX_SRC_BIT] |
                st_q.timer2_control[timer_unit_pkg::TX_SRC_BIT];
  assign cap_sel = st_q.timer2_control[timer_unit_pkg::CAP_RELOAD_BIT];
  assign t2_cnt = {st_q.timer2_high_byte, st_q.timer2_low_byte};
  assign tick2 = st_q.timer2_control[timer_unit_pkg::T2_RUN_BIT] &
    (st_q.timer2_control[timer_unit_pkg::T2_CT_BIT] ?
     fall[timer_unit_pkg::PIN_COUNT2] : mtick);
  assign t2_ovf = tick2 & (t2_cnt == timer_unit_pkg::WORD_MAX);
  assign trig = fall[timer_unit_pkg::PIN_TRIGGER] &
    st_q.timer2_control[timer_unit_pkg::T2_EXT_EN_BIT];

  // One count step of timer 0 or 1; top bit is the overflow.
  function automatic logic [16:0] step_count(input logic [1:0] mode,
      input logic [7:0] lo, input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      timer_unit_pkg::MODE_13BIT: begin
        if (lo[4:0] == timer_unit_pkg::PRESCALE_MAX) begin
          r[4:0] = 5'h00;
          r[15:8] = hi + 8'h01;
          r[16] = (hi == timer_unit_pkg::BYTE_MAX);
        end else begin
          r[4:0] = lo[4:0] + 5'h01;
        end
      end
      timer_unit_pkg::MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h00001;
      end
      timer_unit_pkg::MODE_RELOAD: begin
        if (lo == timer_unit_pkg::BYTE_MAX) begin
          r = {1'b1, hi, hi};
        end else begin
          r[7:0] = lo + 8'h01;
        end
      end
      default: begin
        r[7:0] = lo + 8'h01;
        r[16] = (lo == timer_unit_pkg::BYTE_MAX);
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state: count, then software writes, then flag sets
  // ----------------------------------------------------------------
  logic [16:0] r0;
  logic [16:0] r1;
  logic ovf0;
  logic ovf1;
  logic ovf0h;

  assign r0 = step_count(mode0, st_q.timer0_low_byte, st_q.timer0_high_byte);
  assign r1 = step_count(mode1, st_q.timer1_low_byte, st_q.timer1_high_byte);
  assign ovf0 = tick0 & r0[16];
  assign ovf1 = tick1 & r1[16];
  assign ovf0h = tick0h & (st_q.timer0_high_byte == timer_unit_pkg::BYTE_MAX);

  always_comb begin
    st_d = st_q;
    st_d.rx_tick = 1'b0;
    st_d.tx_tick = 1'b0;
    if (tick0) begin
      st_d.timer0_low_byte = r0[7:0];
      if (mode0 != timer_unit_pkg::MODE_SPLIT) begin
        st_d.timer0_high_byte = r0[15:8];
      end
    end
    if (tick0h) begin
      st_d.timer0_high_byte = st_q.timer0_high_byte + 8'h01;
    end
    if (tick1) begin
      st_d.timer1_low_byte = r1[7:0];
      st_d.timer1_high_byte = r1[15:8];
    end
    if (tick2) begin
      if (t2_ovf && (baud || !cap_sel)) begin
        {st_d.timer2_high_byte, st_d.timer2_low_byte} =
          {st_q.capture_reload_high, st_q.capture_reload_low};
      end else begin
        {st_d.timer2_high_byte, st_d.timer2_low_byte} = t2_cnt + 16'h0001;
      end
    end
    if (trig && !baud) begin
      if (cap_sel) begin
        {st_d.capture_reload_high, st_d.capture_reload_low} = t2_cnt;
      end else begin
        {st_d.timer2_high_byte, st_d.timer2_low_byte} =
          {st_q.capture_reload_high, st_q.capture_reload_low};
      end
    end
    if (SFR_WE) begin
      case (SFR_ADDR)
        timer_unit_pkg::ADDR_TIMER_CONTROL: st_d.timer_control = SFR_WDATA;
        timer_unit_pkg::ADDR_TIMER_MODE: st_d.timer_mode_register = SFR_WDATA;
        timer_unit_pkg::ADDR_T0_LOW: st_d.timer0_low_byte = SFR_WDATA;
        timer_unit_pkg::ADDR_T0_HIGH: st_d.timer0_high_byte = SFR_WDATA;
        timer_unit_pkg::ADDR_T1_LOW: st_d.timer1_low_byte = SFR_WDATA;
        timer_unit_pkg::ADDR_T1_HIGH: st_d.timer1_high_byte = SFR_WDATA;
        timer_unit_pkg::ADDR_T2_CONTROL: st_d.timer2_control = SFR_WDATA;
        timer_unit_pkg::ADDR_CAPTURE_LOW: st_d.capture_reload_low = SFR_WDATA;
        timer_unit_pkg::ADDR_CAPTURE_HIGH: st_d.capture_reload_high = SFR_WDATA;
        timer_unit_pkg::ADDR_T2_LOW: st_d.timer2_low_byte = SFR_WDATA;
        timer_unit_pkg::ADDR_T2_HIGH: st_d.timer2_high_byte = SFR_WDATA;
        default: ;
      endcase
    end
    // Vectoring clears, but a same-cycle overflow still wins
    if (VECTOR0_ACK) begin
      st_d.timer_control[timer_unit_pkg::T0_OVF_BIT] = 1'b0;
    end
    if (VECTOR1_ACK) begin
      st_d.timer_control[timer_unit_pkg::T1_OVF_BIT] = 1'b0;
    end
    if (ovf0) begin
      st_d.timer_control[timer_unit_pkg::T0_OVF_BIT] = 1'b1;
    end
    // split high byte owns timer 1 flag
    if ((mode0 == timer_unit_pkg::MODE_SPLIT) ? ovf0h : ovf1) begin
      st_d.timer_control[timer_unit_pkg::T1_OVF_BIT] = 1'b1;
    end
    // set by overflow, never cleared here
    // not while a serial source is selected
    if (t2_ovf && !baud) begin
      st_d.timer2_control[timer_unit_pkg::T2_OVF_BIT] = 1'b1;
    end
    if (trig && !baud) begin
      st_d.timer2_control[timer_unit_pkg::T2_EXT_BIT] = 1'b1;
    end
    st_d.rx_tick = st_q.timer2_control[timer_unit_pkg::RX_SRC_BIT] ?
      t2_ovf : ovf1;
    st_d.tx_tick = st_q.timer2_control[timer_unit_pkg::TX_SRC_BIT] ?
      t2_ovf : ovf1;
    // Read data shows the value before this cycle's update
    if (SFR_RE) begin
      case (SFR_ADDR)
        timer_unit_pkg::ADDR_TIMER_CONTROL: st_d.rdata = st_q.timer_control;
        timer_unit_pkg::ADDR_TIMER_MODE: st_d.rdata = st_q.timer_mode_register;
        timer_unit_pkg::ADDR_T0_LOW: st_d.rdata = st_q.timer0_low_byte;
        timer_unit_pkg::ADDR_T0_HIGH: st_d.rdata = st_q.timer0_high_byte;
        timer_unit_pkg::ADDR_T1_LOW: st_d.rdata = st_q.timer1_low_byte;
        timer_unit_pkg::ADDR_T1_HIGH: st_d.rdata = st_q.timer1_high_byte;
        timer_unit_pkg::ADDR_T2_CONTROL: st_d.rdata = st_q.timer2_control;
        timer_unit_pkg::ADDR_CAPTURE_LOW: st_d.rdata = st_q.capture_reload_low;
        timer_unit_pkg::ADDR_CAPTURE_HIGH: st_d.rdata = st_q.capture_reload_high;
        timer_unit_pkg::ADDR_T2_LOW: st_d.rdata = st_q.timer2_low_byte;
        timer_unit_pkg::ADDR_T2_HIGH: st_d.rdata = st_q.timer2_high_byte;
        default: st_d.rdata = timer_unit_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SFR_RDATA = st_q.rdata;
  assign TIMER0_IRQ = st_q.timer_control[timer_unit_pkg::T0_OVF_BIT];
  assign TIMER1_IRQ = st_q.timer_control[timer_unit_pkg::T1_OVF_BIT];
  assign TIMER2_IRQ = st_q.timer2_control[timer_unit_pkg::T2_OVF_BIT] |
                      st_q.timer2_control[timer_unit_pkg::T2_EXT_BIT];
  assign RX_BAUD_TICK = st_q.rx_tick;
  assign TX_BAUD_TICK = st_q.tx_tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  timer_cycle_inc_a: assert property (!SFR_WE && tick0 &&
      mode0 == timer_unit_pkg::MODE_16BIT &&
      !st_q.timer_mode_register[timer_unit_pkg::CT0_BIT] &&
      st_q.timer0_low_byte != timer_unit_pkg::BYTE_MAX
      |=> st_q.timer0_low_byte == $past(st_q.timer0_low_byte) + 8'h01)
    else $error("timer 0 missed a machine cycle increment");
  prescale_carry_a: assert property (!SFR_WE && tick0 &&
      mode0 == timer_unit_pkg::MODE_13BIT &&
      st_q.timer0_low_byte[4:0] == timer_unit_pkg::PRESCALE_MAX
      |=> st_q.timer0_low_byte[4:0] == 5'h00 &&
      st_q.timer0_high_byte == $past(st_q.timer0_high_byte) + 8'h01)
    else $error("prescaler carry did not reach high byte");
  reload_copy_a: assert property (!SFR_WE && tick0 &&
      mode0 == timer_unit_pkg::MODE_RELOAD &&
      st_q.timer0_low_byte == timer_unit_pkg::BYTE_MAX
      |=> st_q.timer0_low_byte == $past(st_q.timer0_high_byte) &&
      $stable(st_q.timer0_high_byte) && TIMER0_IRQ)
    else $error("auto reload did not copy high byte");
  gate_hold_a: assert property (!SFR_WE && !en0 &&
      mode0 != timer_unit_pkg::MODE_SPLIT
      |=> $stable({st_q.timer0_high_byte, st_q.timer0_low_byte}))
    else $error("timer 0 moved while not enabled");
  split_stop_a: assert property (!SFR_WE &&
      mode1 == timer_unit_pkg::MODE_SPLIT
      |=> $stable({st_q.timer1_high_byte, st_q.timer1_low_byte}))
    else $error("timer 1 counted in split mode");
  split_high_flag_a: assert property (tick0h && ovf0h && !SFR_WE
      |=> TIMER1_IRQ)
    else $error("split high byte overflow lost");
  t2_flag_sticky_a: assert property (TIMER2_IRQ &&
      st_q.timer2_control[timer_unit_pkg::T2_OVF_BIT] &&
      !(SFR_WE && SFR_ADDR == timer_unit_pkg::ADDR_T2_CONTROL)
      |=> st_q.timer2_control[timer_unit_pkg::T2_OVF_BIT])
    else $error("timer 2 overflow flag cleared by hardware");
  t2_baud_quiet_a: assert property (baud &&
      !st_q.timer2_control[timer_unit_pkg::T2_OVF_BIT] &&
      !(SFR_WE && SFR_ADDR == timer_unit_pkg::ADDR_T2_CONTROL)
      |=> !st_q.timer2_control[timer_unit_pkg::T2_OVF_BIT])
    else $error("timer 2 overflow flag set in serial clock use");
  capture_copy_a: assert property (trig && cap_sel && !baud &&
      !SFR_WE |=> {st_q.capture_reload_high, st_q.capture_reload_low} ==
      $past(t2_cnt) && st_q.timer2_control[timer_unit_pkg::T2_EXT_BIT])
    else $error("capture or external flag missing");
  rx_route_a: assert property (t2_ovf &&
      st_q.timer2_control[timer_unit_pkg::RX_SRC_BIT] |=> RX_BAUD_TICK)
    else $error("receive clock not taken from timer 2");
  tx_route_a: assert property (ovf1 &&
      !st_q.timer2_control[timer_unit_pkg::TX_SRC_BIT] |=> TX_BAUD_TICK)
    else $error("transmit clock not taken from timer 1");

  reload_seen_c: cover property (tick0 &&
      mode0 == timer_unit_pkg::MODE_RELOAD && r0[16]);
  t2_overflow_c: cover property (t2_ovf && !baud);
  capture_seen_c: cover property (trig && cap_sel);
  pin_count_c: cover property (tick1 &&
      st_q.timer_mode_register[timer_unit_pkg::CT1_BIT]);

endmodule
`default_nettype wire

//--- rtl/timer_unit_pkg.sv
// Constants shared by the three-timer unit and its helpers.
// Assumes register addresses on an 8-bit special function register port.
package timer_unit_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_T2_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'hCA;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_T2_LOW = 8'hCC;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hCD;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Timer control register
  localparam int T1_OVF_BIT = 7;
  localparam int T1_RUN_BIT = 6;
  localparam int T0_OVF_BIT = 5;
  localparam int T0_RUN_BIT = 4;
  // Timer mode register
  localparam int GATE1_BIT = 7;
  localparam int CT1_BIT = 6;
  localparam int MODE1_LSB = 4;
  localparam int GATE0_BIT = 3;
  localparam int CT0_BIT = 2;
  localparam int MODE0_LSB = 0;
  // Timer 2 control register
  localparam int T2_OVF_BIT = 7;
  localparam int T2_EXT_BIT = 6;
  localparam int RX_SRC_BIT = 5;
  localparam int TX_SRC_BIT = 4;
  localparam int T2_EXT_EN_BIT = 3;
  localparam int T2_RUN_BIT = 2;
  localparam int T2_CT_BIT = 1;
  localparam int CAP_RELOAD_BIT = 0;

  // ----------------------------------------------------------------
  // Modes and count limits
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Machine cycle: twelve clock phases, numbered from zero
  // ----------------------------------------------------------------
  localparam logic [3:0] PHASE_FIRST = 4'h0;
  localparam logic [3:0] PHASE_LAST = 4'hB;
  localparam logic [3:0] SAMPLE_PHASE_TEN = 4'h9;
  localparam logic [3:0] SAMPLE_PHASE_NINE = 4'h8;

  // ----------------------------------------------------------------
  // Sampled pin indices
  // ----------------------------------------------------------------
  localparam int PIN_COUNT0 = 0;
  localparam int PIN_COUNT1 = 1;
  localparam int PIN_COUNT2 = 2;
  localparam int PIN_TRIGGER = 3;
  localparam int PIN_INT0 = 4;
  localparam int PIN_INT1 = 5;
  localparam int NUM_PINS = 6;

endpackage

//--- rtl/mcycle_gen.sv
// Machine cycle phase counter and its phase strobes.
// Assumes one clock per oscillator period; twelve make a machine cycle.
`timescale 1ns/1ps
`default_nettype none
module mcycle_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Phase strobes
  output logic mtick,
  output logic ph_ten,
  output logic ph_nine
);

  typedef struct packed {
    logic [3:0] phase;
  } state_t;

  state_t st_q;
  state_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.phase == timer_unit_pkg::PHASE_LAST) begin
      st_d.phase = timer_unit_pkg::PHASE_FIRST;
    end else begin
      st_d.phase = st_q.phase + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mtick = (st_q.phase == timer_unit_pkg::PHASE_LAST);
  assign ph_ten = (st_q.phase == timer_unit_pkg::SAMPLE_PHASE_TEN);
  assign ph_nine = (st_q.phase == timer_unit_pkg::SAMPLE_PHASE_NINE);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  tick_spacing_a: assert property (mtick |=> !mtick [*8])
    else $error("machine tick repeated within a cycle");

endmodule
`default_nettype wire

//--- rtl/event_sampler.sv
// Pin synchroniser with once-per-machine-cycle sampling and fall detect.
// Assumes strobe pulses one clock per machine cycle.
`timescale 1ns/1ps
`default_nettype none
module event_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin and sample strobe
  input wire logic pin,
  input wire logic strobe,
  // Filtered level and detected fall
  output logic level,
  output logic fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic samp;
    logic fall;
  } state_t;

  state_t st_q;
  state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Level moves only once the last two stages agree
    if (st_q.s2 == st_q.s3) begin
      st_d.filt = st_q.s3;
    end
    st_d.fall = 1'b0;
    if (strobe) begin
      st_d.samp = st_q.filt;
      st_d.fall = st_q.samp & ~st_q.filt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.filt;
  assign fall = st_q.fall;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  fall_after_strobe_a: assert property (fall |-> $past(strobe))
    else $error("fall reported outside a sample phase");
  fall_needs_high_a: assert property (fall |-> $past(st_q.samp) &&
      !$past(st_q.filt))
    else $error("fall reported without high then low");
  fall_seen_c: cover property (fall);

endmodule
`default_nettype wire

//--- tb/pin_model.sv
// Far-side pins: count pulses on request, gate held high.
// Assumes start is a one-clock pulse.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Clock and request
  input wire logic clk,
  input wire logic start,
  input wire logic [2:0] pulses,
  // Pins
  output logic count_pin,
  output logic gate_pin
);
  int n;
  initial begin
    count_pin = 1'b0;
    gate_pin = 1'b1;
    forever begin
      @(posedge clk iff start);
      n = pulses;
      // Pin moves on the falling edge, clear of the sampling edge
      @(negedge clk);
      // each level held two machine cycles
      repeat (n) begin
        count_pin = 1'b1;
        repeat (24) @(negedge clk);
        count_pin = 1'b0;
        repeat (24) @(negedge clk);
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/timer_unit_tb.sv
// Self-checking bench for the three-timer unit.
// Assumes pin_model on the count and gate pins; trigger driven here.
`timescale 1ns/1ps
`default_nettype none
module timer_unit_tb;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, go = 1'b0, re_q;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got, seen;
  logic pk = 1'b0, pk_q, ack = 1'b0, trg = 1'b1;
  logic irq0, irq1, irq2, rxt, txt;
  logic [1:0] rx_n = 2'h0, tx_n = 2'h0;
  logic [2:0] np = 3'h1;
  logic cnt, gate;
  logic [7:0] exp_q[$];
  int err_count = 0, check_count = 0, seed = 32'h2219;
  always #4 clk = ~clk;
  timer_unit timer_unit_i (.MCLK(clk), .RST(rst), .SFR_ADDR(addr),
    .SFR_WDATA(wdata), .SFR_WE(we), .SFR_RE(re), .SFR_RDATA(rdata),
    .COUNT0_PIN(cnt), .COUNT1_PIN(cnt), .COUNT2_PIN(cnt),
    .TIMER2_TRIGGER_PIN(trg), .EXT_INT0_PIN(gate), .EXT_INT1_PIN(gate),
    .TIMER0_IRQ(irq0), .TIMER1_IRQ(irq1), .TIMER2_IRQ(irq2),
    .VECTOR0_ACK(ack), .VECTOR1_ACK(1'b0), .RX_BAUD_TICK(rxt),
    .TX_BAUD_TICK(txt));
  pin_model pin_model_i (.clk(clk), .start(go), .pulses(np),
    .count_pin(cnt), .gate_pin(gate));
  // --------------------------------------------------------------
  // Bus tasks and read monitor
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    re = 1'b0;
  endtask
  // Notes the interrupt levels and baud tick counts as one byte
  task automatic obs(input logic [7:0] e);
    @(negedge clk);
    pk = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    pk = 1'b0;
  endtask
  always @(posedge clk) begin
    re_q <= re;
    pk_q <= pk;
    if (!rst) begin
      rx_n <= rx_n + {1'b0, rxt};
      tx_n <= tx_n + {1'b0, txt};
    end
  end
  always @(negedge clk) begin
    if (re_q || pk_q) begin
      got = exp_q.pop_front();
      seen = re_q ? rdata : {irq0, irq1, irq2, 1'b0, rx_n, tx_n};
      check_count++;
      if (seen !== got) begin
        err_count++;
        $display("[FAIL] %0t got %h exp %h", $time, seen, got);
      end
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(8'hC8, 8'h00);
    rd(8'h55, 8'h00);
    $display("reset values done");
    np = 3'(($random(seed) & 3) + 1);
    wr(8'h89, 8'h0D);
    wr(8'h88, 8'h10);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (48 * np + 40) @(negedge clk);
    rd(8'h8A, {5'h00, np});
    $display("gated counter done");
    wr(8'h89, 8'h02);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFE);
    wr(8'h88, 8'h10);
    // 24 edges from the low byte write hold exactly two machine ticks
    repeat (20) @(negedge clk);
    // Counter select with an idle pin stops the count, flag kept
    wr(8'h89, 8'h06);
    rd(8'h88, 8'h30);
    rd(8'h8A, 8'hFE);
    rd(8'h8C, 8'hFE);
    obs(8'h80);
    $display("reload mode done");
    wr(8'h8C, 8'h7F);
    wr(8'h8A, 8'h1F);
    wr(8'h89, 8'h00);
    // 12 edges: exactly one machine tick
    repeat (10) @(negedge clk);
    wr(8'h89, 8'h04);
    rd(8'h8A, 8'h00);
    rd(8'h8C, 8'h80);
    $display("mode 0 done");
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    repeat (24) @(negedge clk);
    rd(8'hC8, 8'h84);
    obs(8'hA0);
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h34);
    repeat (24) @(negedge clk);
    rd(8'hC8, 8'h34);
    obs(8'h85);
    $display("timer 2 done");
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h5A);
    wr(8'hCD, 8'hA5);
    wr(8'hC8, 8'h09);
    trg = 1'b0;
    repeat (24) @(negedge clk);
    rd(8'hCA, 8'h5A);
    rd(8'hCB, 8'hA5);
    rd(8'hC8, 8'h49);
    obs(8'hA5);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    obs(8'h25);
    $display("capture done");
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
